//--- design/plic_pkg.sv
// How it works
// RULE1: Sixteen program levels; fifteen is highest priority, zero lowest.
// RULE2: Level 14 internal, 13 to 10 vectored, 15 fast user, 9 to 0 software.
// RULE3: Program may set any level; devices may raise only 15 and 13 to 10.
// RULE4: Enable and detect masks are 16 bits; hardware changes only detect.
// RULE5: Running level is the highest level set in both masks.
// RULE6: Masks support read, full write, masked set and masked clear.
// RULE7: Reset clears the enable mask and selects level zero.
// RULE8: Interrupt on enables level switching and lights the interrupt lamp.
// RULE9: Interrupt off freezes the running level and darkens the lamp.
// RULE10: Four identify variants, one per vectored level 10 to 13.
// RULE11: Identify returns the device code in bits 0 to 8, upper bits zero.
// RULE12: No answer leaves accumulator alone and raises level 14 if enabled.
// RULE13: Slot order picks the answerer; request line stays until all served.
// RULE14: A device drops its request once it answers identification.
// RULE15: Up to 2048 device sources, each with its own code and priority.
// RULE16: Paging on makes the next instruction use translation.
// RULE17: Paging off removes translation and all protection.
// RULE18: Combined instructions switch paging and interrupt system together.
// RULE19: Set extended selects 24-bit addressing and sets status bit 13.
// RULE20: Reset extended selects 19-bit addressing and clears status bit 13.
// RULE21: Give up priority with interrupts off halts and lights operator lamp.
// RULE22: With interrupts on it clears own detect bit; ignored on level 0.
// RULE23: Monitor call raises level 14 and loads sign-extended parameter to T.
package plic_pkg;

    localparam int          NUM_LEVELS      = 16;
    localparam int          LVL_W           = 4;
    localparam int          WORD_W          = 16;
    localparam int          ID_CODE_W       = 9;
    localparam int          MON_PARAM_W     = 8;
    localparam int          STS_EXT_BIT     = 13;
    localparam logic [15:0] EXT_LEVEL_MASK  = 16'hBC00;
    localparam logic [3:0]  LVL_INTERNAL    = 4'hE;
    localparam logic [3:0]  LVL_ZERO        = 4'h0;
    localparam logic [3:0]  LVL_IDENT_BASE  = 4'hA;
    localparam logic [15:0] ENABLE_RST      = 16'h0000;
    localparam logic [15:0] DETECT_RST      = 16'h0000;
    localparam logic [3:0]  REG_DETECT      = 4'h6;
    localparam logic [3:0]  REG_ENABLE      = 4'h7;
    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          IDENT_WAIT_NS   = 1000;
    localparam int          IDENT_WAIT_CYC  = IDENT_WAIT_NS / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        OP_NONE  = 4'h0,
        OP_RD    = 4'h1,
        OP_WR    = 4'h2,
        OP_MSET  = 4'h3,
        OP_MCLR  = 4'h4,
        OP_ION   = 4'h5,
        OP_IOF   = 4'h6,
        OP_IDENT = 4'h7,
        OP_PON   = 4'h8,
        OP_POF   = 4'h9,
        OP_PAGING_IRQ_ON  = 4'hA,
        OP_PAGING_IRQ_OFF  = 4'hB,
        OP_SEX   = 4'hC,
        OP_REX   = 4'hD,
        OP_WAIT  = 4'hE,
        OP_MON   = 4'hF
    } plic_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_IDENT = 2'b01,
        ST_HALT  = 2'b10
    } plic_state_t;

    typedef struct packed {
        logic              valid;
        plic_op_t          op;
        logic [WORD_W-1:0] arg;
        logic [WORD_W-1:0] acc;
    } plic_instr_t;

endpackage : plic_pkg

//--- design/plic_core.sv
`timescale 1ns/100ps
`default_nettype none
module plic_core
    import plic_pkg::*;
#(
    parameter int IDENT_WAIT = IDENT_WAIT_CYC
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire plic_instr_t          instr,
    input  wire logic [WORD_W-1:0]    ext_irq_req,
    input  wire logic                 ident_ack,
    input  wire logic [ID_CODE_W-1:0] ident_code,
    input  wire logic                 iox_err_en,
    input  wire logic                 console_continue,
    output logic                      instr_ready_r,
    output logic [WORD_W-1:0]         acc_out_r,
    output logic                      acc_we_r,
    output logic [WORD_W-1:0]         level_enable_mask_r,
    output logic [WORD_W-1:0]         level_detect_mask_r,
    output logic [LVL_W-1:0]          current_level_reg_r,
    output logic                      irq_sys_on_r,
    output logic                      paging_on_r,
    output logic                      extended_r,
    output logic                      operator_lamp_r,
    output logic                      ident_req_r,
    output logic [LVL_W-1:0]          ident_level_r,
    output logic [WORD_W-1:0]         t14_data_r,
    output logic                      t14_we_r
);

    localparam int CNT_W = $clog2(IDENT_WAIT + 1);

    if (IDENT_WAIT < 1) begin : g_bad_wait
        $error("IDENT_WAIT must be at least one cycle.");
    end

    // Highest level set in the mask, or level zero when none is set.
    function automatic logic [LVL_W-1:0] hi_lvl(input logic [WORD_W-1:0] m);
        hi_lvl = LVL_ZERO;
        for (int i = 0; i < NUM_LEVELS; i++) begin
            if (m[i]) begin
                hi_lvl = LVL_W'(i);                      // [RULE1]
            end
        end
    endfunction : hi_lvl

    function automatic logic [WORD_W-1:0] apply_op(
        input plic_op_t          op,
        input logic [WORD_W-1:0] old,
        input logic [WORD_W-1:0] acc
    );
        case (op)
            OP_WR:   apply_op = acc;
            OP_MSET: apply_op = old | acc;
            OP_MCLR: apply_op = old & ~acc;
            default: apply_op = old;
        endcase
    endfunction : apply_op

    plic_state_t       state_r, state_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    logic [WORD_W-1:0] en_nxt, det_nxt, hw_set;
    logic [WORD_W-1:0] acc_nxt, t14_nxt;
    logic [LVL_W-1:0]  cur_nxt, id_lvl_nxt;
    logic              acc_we_nxt, t14_we_nxt, on_nxt, pg_nxt, ext_nxt;
    logic              lamp_nxt, id_req_nxt, ready_nxt, take;
    logic              id_timeout;

    assign take = instr.valid && (state_r == ST_IDLE);
    assign id_timeout = (state_r == ST_IDENT) && !ident_ack
                        && (cnt_r == CNT_W'(IDENT_WAIT - 1));

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        en_nxt     = level_enable_mask_r;
        det_nxt    = level_detect_mask_r;
        acc_nxt    = acc_out_r;
        acc_we_nxt = 1'b0;
        t14_nxt    = t14_data_r;
        t14_we_nxt = 1'b0;
        on_nxt     = irq_sys_on_r;
        pg_nxt     = paging_on_r;
        ext_nxt    = extended_r;
        lamp_nxt   = operator_lamp_r;
        id_req_nxt = ident_req_r;
        id_lvl_nxt = ident_level_r;
        // Devices may only reach their own levels; others are masked off.
        hw_set     = ext_irq_req & EXT_LEVEL_MASK;              // [RULE3]
        if (take) begin
            case (instr.op)
                OP_RD: begin
                    // Unknown register codes clear the accumulator.
                    case (instr.arg[3:0])
                        REG_DETECT: acc_nxt = level_detect_mask_r;
                        REG_ENABLE: acc_nxt = level_enable_mask_r;
                        default:    acc_nxt = '0;
                    endcase
                    acc_we_nxt = 1'b1;                           // [RULE6]
                end
                OP_WR, OP_MSET, OP_MCLR: begin
                    if (instr.arg[3:0] == REG_ENABLE) begin
                        en_nxt = apply_op(instr.op, level_enable_mask_r,
                                          instr.acc);            // [RULE4]
                    end
                    if (instr.arg[3:0] == REG_DETECT) begin
                        det_nxt = apply_op(instr.op, level_detect_mask_r,
                                           instr.acc);           // [RULE6]
                    end
                end
                OP_ION: begin
                    on_nxt = 1'b1;                               // [RULE8]
                end
                OP_IOF: begin
                    on_nxt = 1'b0;                               // [RULE9]
                end
                OP_IDENT: begin
                    state_nxt  = ST_IDENT;
                    cnt_nxt    = '0;
                    id_req_nxt = 1'b1;
                    id_lvl_nxt = LVL_IDENT_BASE
                                 + {2'b00, instr.arg[1:0]};      // [RULE10]
                end
                OP_PON: begin
                    pg_nxt = 1'b1;                               // [RULE16]
                end
                OP_POF: begin
                    pg_nxt = 1'b0;                               // [RULE17]
                end
                OP_PAGING_IRQ_ON: begin
                    pg_nxt = 1'b1;                               // [RULE18]
                    on_nxt = 1'b1;
                end
                OP_PAGING_IRQ_OFF: begin
                    pg_nxt = 1'b0;                               // [RULE18]
                    on_nxt = 1'b0;
                end
                OP_SEX: begin
                    ext_nxt = 1'b1;                              // [RULE19]
                end
                OP_REX: begin
                    ext_nxt = 1'b0;                              // [RULE20]
                end
                OP_WAIT: begin
                    if (!irq_sys_on_r) begin
                        state_nxt = ST_HALT;                     // [RULE21]
                        lamp_nxt  = 1'b1;
                    end else if (current_level_reg_r != LVL_ZERO) begin
                        det_nxt[current_level_reg_r] = 1'b0;     // [RULE22]
                    end
                end
                OP_MON: begin
                    hw_set[LVL_INTERNAL] = 1'b1;         // [RULE2] [RULE23]
                    t14_nxt = {{(WORD_W - MON_PARAM_W){instr.arg[7]}},
                               instr.arg[MON_PARAM_W-1:0]};
                    t14_we_nxt = 1'b1;
                end
                default: begin
                end
            endcase
        end
        case (state_r)
            ST_IDENT: begin
                cnt_nxt = cnt_r + CNT_W'(1);
                if (ident_ack) begin
                    // The winning slot answers; others keep requesting.
                    acc_nxt    = {{(WORD_W - ID_CODE_W){1'b0}},
                                  ident_code};           // [RULE11] [RULE15]
                    acc_we_nxt = 1'b1;                           // [RULE13]
                    id_req_nxt = 1'b0;
                    state_nxt  = ST_IDLE;
                end else if (id_timeout) begin
                    hw_set[LVL_INTERNAL] = hw_set[LVL_INTERNAL]
                                           | iox_err_en;         // [RULE12]
                    id_req_nxt = 1'b0;
                    state_nxt  = ST_IDLE;
                end
            end
            ST_HALT: begin
                if (console_continue) begin
                    lamp_nxt  = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
            end
        endcase
        // A hardware request wins over a program clear in the same cycle.
        det_nxt = det_nxt | hw_set;                              // [RULE4]
        // With switching off the running level is frozen.
        cur_nxt = irq_sys_on_r
                  ? hi_lvl(level_enable_mask_r & level_detect_mask_r)
                  : current_level_reg_r;                         // [RULE5]
        ready_nxt = (state_nxt == ST_IDLE);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r             <= ST_IDLE;
            cnt_r               <= '0;
            level_enable_mask_r <= ENABLE_RST;                   // [RULE7]
            level_detect_mask_r <= DETECT_RST;
            current_level_reg_r <= LVL_ZERO;                     // [RULE7]
            acc_out_r           <= '0;
            acc_we_r            <= 1'b0;
            t14_data_r          <= '0;
            t14_we_r            <= 1'b0;
            irq_sys_on_r        <= 1'b0;
            paging_on_r         <= 1'b0;
            extended_r          <= 1'b0;
            operator_lamp_r     <= 1'b0;
            ident_req_r         <= 1'b0;
            ident_level_r       <= LVL_ZERO;
            instr_ready_r       <= 1'b1;
        end else begin
            state_r             <= state_nxt;
            cnt_r               <= cnt_nxt;
            level_enable_mask_r <= en_nxt;
            level_detect_mask_r <= det_nxt;
            current_level_reg_r <= cur_nxt;
            acc_out_r           <= acc_nxt;
            acc_we_r            <= acc_we_nxt;
            t14_data_r          <= t14_nxt;
            t14_we_r            <= t14_we_nxt;
            irq_sys_on_r        <= on_nxt;
            paging_on_r         <= pg_nxt;
            extended_r          <= ext_nxt;
            operator_lamp_r     <= lamp_nxt;
            ident_req_r         <= id_req_nxt;
            ident_level_r       <= id_lvl_nxt;
            instr_ready_r       <= ready_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_level_track: assert property ( // [RULE5]
        irq_sys_on_r |=> current_level_reg_r
            == hi_lvl($past(level_enable_mask_r & level_detect_mask_r)))
        else $error("Running level is not the highest eligible level.");

    chk_off_hold: assert property ( // [RULE9]
        !irq_sys_on_r |=> $stable(current_level_reg_r))
        else $error("Running level moved while switching was off.");

    chk_ident_data: assert property ( // [RULE11]
        (state_r == ST_IDENT) && ident_ack |=> acc_we_r
            && acc_out_r == {7'h00, $past(ident_code)} && !ident_req_r)
        else $error("Identify answer not returned in the accumulator.");

    chk_ident_miss: assert property ( // [RULE12]
        id_timeout |=> !acc_we_r && !ident_req_r
            && (level_detect_mask_r[14] || !$past(iox_err_en)))
        else $error("Unanswered identify handled wrongly.");

    chk_mon_load: assert property ( // [RULE23]
        take && instr.op == OP_MON |=> t14_we_r
            && level_detect_mask_r[14]
            && t14_data_r == {{8{$past(instr.arg[7])}},
                              $past(instr.arg[7:0])})
        else $error("Monitor call did not raise level 14 with its value.");

    chk_ext_mode: assert property ( // [RULE19]
        take && instr.op == OP_SEX |=> extended_r [*1] ##1 1'b1)
        else $error("Extended mode not set.");

    chk_wait_halt: assert property ( // [RULE21]
        take && instr.op == OP_WAIT && !irq_sys_on_r
            |=> operator_lamp_r && !instr_ready_r
                && (state_r == ST_HALT))
        else $error("Wait with interrupts off did not halt.");

    chk_wait_clear: assert property ( // [RULE22]
        take && instr.op == OP_WAIT && irq_sys_on_r
            && current_level_reg_r != LVL_ZERO
            && !hw_set[current_level_reg_r]
            |=> !level_detect_mask_r[$past(current_level_reg_r)])
        else $error("Give up priority left the detect bit set.");

    chk_mask_set: assert property ( // [RULE6]
        take && instr.op == OP_MSET && instr.arg[3:0] == REG_ENABLE
            |=> level_enable_mask_r
                == ($past(level_enable_mask_r) | $past(instr.acc)))
        else $error("Masked set of the enable mask failed.");

    chk_ext_only: assert property ( // [RULE3]
        !take && state_r == ST_IDLE && ext_irq_req[9]
            && !level_detect_mask_r[9] |=> !level_detect_mask_r[9])
        else $error("Device request reached a software level.");

    cov_ident_ok: cover property (
        take && instr.op == OP_IDENT ##[1:8] ident_ack);
    cov_ident_miss: cover property (id_timeout);
    cov_wait_halt: cover property (
        state_r == ST_HALT ##1 console_continue);
    cov_switch: cover property (
        irq_sys_on_r ##1 $changed(current_level_reg_r));

endmodule : plic_core
`default_nettype wire

//--- testbench/plic_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module plic_dev_model
    import plic_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 ident_req_r,
    input  wire logic [LVL_W-1:0]     ident_level_r,
    input  wire logic [WORD_W-1:0]    post_req,
    input  wire logic                 post_slot,
    input  wire logic [2:0]           ans_delay,
    input  wire logic [WORD_W-1:0]    stray,
    output logic [WORD_W-1:0]         ext_irq_req,
    output logic                      ident_ack,
    output logic [ID_CODE_W-1:0]      ident_code
);
    // Two device slots per level; slot 0 sits nearer the processor.
    logic [WORD_W-1:0] pend0, pend1;
    logic [2:0]        waitc;
    logic              done;

    // Stray lines let the bench break the level restriction on purpose.
    assign ext_irq_req = ((pend0 | pend1) & EXT_LEVEL_MASK)
                         | stray;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend0 <= '0;
            pend1 <= '0;
            ident_ack <= 1'b0;
            ident_code <= 9'h0AA;
            waitc <= '0;
            done <= 1'b0;
        end else begin
            ident_ack <= 1'b0;
            // Code lines are not held outside an answer.
            ident_code <= ~ident_code;
            if (post_slot) begin
                pend1 <= pend1 | (post_req & EXT_LEVEL_MASK);
            end else begin
                pend0 <= pend0 | (post_req & EXT_LEVEL_MASK);
            end
            if (!ident_req_r) begin
                waitc <= '0;
                done <= 1'b0;
            end else if (!done
                && (pend0[ident_level_r] | pend1[ident_level_r])) begin
                if (waitc == ans_delay) begin
                    ident_ack <= 1'b1;
                    done <= 1'b1;
                    if (pend0[ident_level_r]) begin
                        pend0[ident_level_r] <= 1'b0;
                        ident_code <= {ident_level_r, 4'h0, 1'b0};
                    end else begin
                        pend1[ident_level_r] <= 1'b0;
                        ident_code <= {ident_level_r, 4'h0, 1'b1};
                    end
                end else waitc <= waitc + 3'h1;
            end
        end
    end
endmodule : plic_dev_model
`default_nettype wire

//--- testbench/program_level_interrupt_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module program_level_interrupt_control_tb_top import plic_pkg::*; ();
    logic                 core_clk, rst, iox_err_en, console_continue;
    plic_instr_t          instr;
    logic [WORD_W-1:0]    ext_irq_req, post_req, stray, acc_out_r, t14_data_r;
    logic [WORD_W-1:0]    level_enable_mask_r, level_detect_mask_r, v, m;
    logic                 ident_ack, post_slot, instr_ready_r, acc_we_r;
    logic                 irq_sys_on_r, paging_on_r, extended_r, ident_req_r;
    logic                 operator_lamp_r, t14_we_r;
    logic [ID_CODE_W-1:0] ident_code;
    logic [2:0]           ans_delay;
    logic [LVL_W-1:0]     current_level_reg_r, ident_level_r, lv, code;
    logic [WORD_W-1:0]    acc_q[$], t14_q[$];
    integer               seed = 32'hdc4edcf4;
    int                   mismatches = 0, num_checks = 0, cycles = 0;
    plic_op_t             pops[6] = '{OP_PON, OP_POF, OP_PAGING_IRQ_ON, OP_PAGING_IRQ_OFF,
                                      OP_SEX, OP_REX};
    logic [2:0]           pexp[6] = '{3'h2, 3'h0, 3'h6, 3'h0, 3'h1, 3'h0};

    plic_core #(.IDENT_WAIT(8)) dut (.core_clk, .rst, .instr, .ext_irq_req,
        .ident_ack, .ident_code, .iox_err_en, .console_continue,
        .instr_ready_r, .acc_out_r, .acc_we_r, .level_enable_mask_r,
        .level_detect_mask_r, .current_level_reg_r, .irq_sys_on_r,
        .paging_on_r, .extended_r, .operator_lamp_r, .ident_req_r,
        .ident_level_r, .t14_data_r, .t14_we_r);
    plic_dev_model dev (.core_clk, .rst, .ident_req_r, .ident_level_r,
        .post_req, .post_slot, .ans_delay, .stray, .ext_irq_req, .ident_ack,
        .ident_code);

    always #2 core_clk = ~core_clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    task automatic exec(input plic_op_t op, input logic [15:0] arg,
                        input logic [15:0] acc);
        @(negedge core_clk);
        while (instr_ready_r !== 1'b1) @(negedge core_clk);
        instr <= '{valid: 1'b1, op: op, arg: arg, acc: acc};
        @(negedge core_clk);
        instr.valid <= 1'b0;
    endtask : exec

    task automatic wreg(input plic_op_t op, input logic [3:0] c,
                        input logic [15:0] val);
        exec(op, {12'h000, c}, val);
    endtask : wreg

    task automatic rd(input logic [3:0] c, input logic [15:0] exp);
        acc_q.push_back(exp);
        exec(OP_RD, {12'h000, c}, 16'h0000);
    endtask : rd

    task automatic settle();
        repeat (2) @(negedge core_clk);
    endtask : settle

    task automatic wait_ready();
        repeat (20) if (instr_ready_r !== 1'b1) @(negedge core_clk);
    endtask : wait_ready

    function automatic logic [3:0] top_level(input logic [15:0] x);
        top_level = 4'h0;
        for (int i = 0; i < 16; i++) if (x[i]) top_level = 4'(i);
    endfunction : top_level

    // Every accumulator or T load must match the oldest expectation.
    always @(negedge core_clk) begin
        if (acc_we_r === 1'b1) begin
            if (acc_q.size() == 0) chk(16'h0001, 16'h0000);
            else chk(acc_out_r, acc_q.pop_front());
        end
        if (t14_we_r === 1'b1) begin
            if (t14_q.size() == 0) chk(16'h0001, 16'h0000);
            else chk(t14_data_r, t14_q.pop_front());
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        instr = '0;
        iox_err_en = 1'b0;
        console_continue = 1'b0;
        post_req = '0;
        post_slot = 1'b0;
        stray = '0;
        ans_delay = 3'h0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        chk(level_enable_mask_r, 16'h0000);
        chk(16'(current_level_reg_r), 16'h0000);
        for (int r = 0; r < 2; r++) begin
            code = r ? REG_ENABLE : REG_DETECT;
            v = 16'($random(seed));
            m = 16'($random(seed));
            wreg(OP_WR, code, v);
            rd(code, v);
            wreg(OP_MSET, code, m);
            rd(code, v | m);
            wreg(OP_MCLR, code, m);
            rd(code, v & ~m);
        end
        rd(4'h3, 16'h0000);
        exec(OP_ION, 16'h0000, 16'h0000);
        chk(16'(irq_sys_on_r), 16'h0001);
        for (int i = 0; i < 6; i++) begin
            v = 16'($random(seed));
            m = 16'($random(seed));
            wreg(OP_WR, REG_ENABLE, v);
            wreg(OP_WR, REG_DETECT, m);
            settle();
            lv = top_level(v & m);
            chk(16'(current_level_reg_r), 16'(lv));
        end
        exec(OP_IOF, 16'h0000, 16'h0000);
        wreg(OP_WR, REG_ENABLE, 16'hFFFF);
        wreg(OP_WR, REG_DETECT, 16'h8000);
        settle();
        chk(16'(current_level_reg_r), 16'(lv));
        chk(16'(irq_sys_on_r), 16'h0000);
        wreg(OP_WR, REG_DETECT, 16'h0000);
        // An unknown register code must leave the detect mask alone.
        wreg(OP_WR, 4'h3, 16'hFFFF);
        stray <= 16'h43FF;
        settle();
        stray <= 16'h0000;
        rd(REG_DETECT, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            @(negedge core_clk) post_req <= 16'h3C00;
            post_slot <= 1'(s);
            @(negedge core_clk) post_req <= 16'h0000;
        end
        rd(REG_DETECT, 16'h3C00);
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 2; s++) begin
                ans_delay <= s ? 3'h4 : 3'h0;
                acc_q.push_back({7'h00, 4'(10 + k), 4'h0, 1'(s)});
                exec(OP_IDENT, 16'(k), 16'hFFFF);
                wait_ready();
                chk(16'(ext_irq_req[10 + k]), 16'(1 - s));
            end
        end
        for (int e = 1; e >= 0; e--) begin
            iox_err_en <= 1'(e);
            wreg(OP_WR, REG_DETECT, 16'h0000);
            exec(OP_IDENT, 16'h0000, 16'hFFFF);
            wait_ready();
            rd(REG_DETECT, e ? 16'h4000 : 16'h0000);
        end
        exec(OP_ION, 16'h0000, 16'h0000);
        wreg(OP_WR, REG_DETECT, 16'h0000);
        settle();
        chk(16'(current_level_reg_r), 16'h0000);
        for (int p = 0; p < 3; p++) begin
            m = (p == 2) ? 16'($random(seed)) : (p ? 16'h007F : 16'h0080);
            t14_q.push_back({{8{m[7]}}, m[7:0]});
            exec(OP_MON, {8'h00, m[7:0]}, 16'h0000);
            settle();
            chk(16'(current_level_reg_r), 16'h000E);
            exec(OP_WAIT, 16'h0000, 16'h0000);
            settle();
            chk(16'(current_level_reg_r), 16'h0000);
        end
        rd(REG_DETECT, 16'h0000);
        wreg(OP_WR, REG_DETECT, 16'h1204);
        exec(OP_WAIT, 16'h0000, 16'h0000);
        settle();
        chk(16'(current_level_reg_r), 16'h0009);
        wreg(OP_WR, REG_DETECT, 16'h0001);
        exec(OP_WAIT, 16'h0000, 16'h0000);
        rd(REG_DETECT, 16'h0001);
        exec(OP_IOF, 16'h0000, 16'h0000);
        exec(OP_WAIT, 16'h0000, 16'h0000);
        chk(16'({operator_lamp_r, instr_ready_r}), 16'h0002);
        console_continue <= 1'b1;
        wait_ready();
        console_continue <= 1'b0;
        chk(16'(operator_lamp_r), 16'h0000);
        for (int i = 0; i < 6; i++) begin
            exec(pops[i], 16'h0000, 16'h0000);
            lv = {1'b0, irq_sys_on_r, paging_on_r, extended_r};
            chk(16'(lv), 16'(pexp[i]));
        end
        settle();
        finish_test();
    end
endmodule : program_level_interrupt_control_tb_top
`default_nettype wire
